// *** src/ovr_top.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module ovr_top
#(
	parameter int CHANNELS = 8
)
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// register port
	input wire logic [ovr_pkg::SEL_W-1:0] ADDR,
	input wire logic [ovr_pkg::WORD_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [ovr_pkg::WORD_W-1:0] RDATA,
	output logic RDATA_VALID,
	// range codes from the range registers, two bits per channel
	input wire logic [2*CHANNELS-1:0] RANGE_A,
	input wire logic [2*CHANNELS-1:0] RANGE_B,
	// headroom enables per channel
	output logic [CHANNELS-1:0] HEADROOM_A,
	output logic [CHANNELS-1:0] HEADROOM_B,
	// resulting full scale per channel in millivolts
	output logic [CHANNELS*ovr_pkg::FS_W-1:0] FULL_SCALE_A,
	output logic [CHANNELS*ovr_pkg::FS_W-1:0] FULL_SCALE_B
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// the word holds exactly eight enables, so the group width is fixed
	if (CHANNELS != ovr_pkg::EN_W)
	begin : g_bad_width
		$error("CHANNELS must equal the eight enables of a register word");
	end

	// ----------------------------------------------------------------
	// address helpers
	// ----------------------------------------------------------------
	// used only by the fault event decode, for writes and both kinds of read
	function automatic logic is_group(input logic [ovr_pkg::SEL_W-1:0] a);
		return (a == ovr_pkg::ADDR_GROUP_A) || (a == ovr_pkg::ADDR_GROUP_B);
	endfunction

	function automatic logic is_mapped(input logic [ovr_pkg::SEL_W-1:0] a);
		return is_group(a) || (a == ovr_pkg::ADDR_FAULTS);
	endfunction

	// ----------------------------------------------------------------
	// incoming word
	// ----------------------------------------------------------------
	ovr_pkg::ovr_word_t cmd;
	ovr_pkg::ovr_word_t word_a;
	ovr_pkg::ovr_word_t word_b;

	// view the write data as a register word
	assign cmd = ovr_pkg::ovr_word_t'(WDATA);

	logic wr_cmd;
	logic rd_cmd;
	logic sel_ok;
	logic wr_a;
	logic wr_b;

	// a write strobe with direction 1 is a write, with direction 0 a read request
	assign wr_cmd = WR && (cmd.dir == ovr_pkg::DIR_WRITE);
	assign rd_cmd = WR && (cmd.dir == ovr_pkg::DIR_READ);
	// the select inside the word must name the port address, or nothing is written
	assign sel_ok = (cmd.sel == ADDR);

	// write decode; only the enables reach the group registers
	always_comb
	begin
		wr_a = 1'b0;
		wr_b = 1'b0;
		if (wr_cmd && sel_ok && (ADDR == ovr_pkg::ADDR_GROUP_A))
			wr_a = 1'b1;
		else if (wr_cmd && sel_ok && (ADDR == ovr_pkg::ADDR_GROUP_B))
			wr_b = 1'b1;
	end

	// ----------------------------------------------------------------
	// group registers
	// ----------------------------------------------------------------
	ovr_group_reg
	#(
		.RESET_WORD(ovr_pkg::RESET_GROUP_A)
	)
	u_group_a
	(
		.clk(MCLK),
		.rst(RST),
		.wr_en(wr_a),
		.wr_bits(cmd.en),
		.word(word_a)
	);

	ovr_group_reg
	#(
		.RESET_WORD(ovr_pkg::RESET_GROUP_B)
	)
	u_group_b
	(
		.clk(MCLK),
		.rst(RST),
		.wr_en(wr_b),
		.wr_bits(cmd.en),
		.word(word_b)
	);

	// ----------------------------------------------------------------
	// fault register
	// ----------------------------------------------------------------
	logic flt_mismatch;
	logic flt_unmapped;
	logic flt_rsvd;
	logic [ovr_pkg::SEL_W-1:0] flt_sel;
	logic next_flt_mismatch;
	logic next_flt_unmapped;
	logic next_flt_rsvd;
	logic [ovr_pkg::SEL_W-1:0] next_flt_sel;
	logic set_mismatch;
	logic set_unmapped;
	logic set_rsvd;
	logic clr_faults;

	// events that software later inspects
	assign set_mismatch = wr_cmd && !sel_ok;
	assign set_unmapped = (wr_cmd && sel_ok && !is_group(ADDR)) || (rd_cmd && !is_mapped(cmd.sel))
		|| (RD && !is_mapped(ADDR));
	assign set_rsvd = wr_cmd && sel_ok && is_group(ADDR) && cmd.rsvd;
	// reading the fault word clears it, by either read path
	assign clr_faults = (RD && (ADDR == ovr_pkg::ADDR_FAULTS))
		|| (rd_cmd && (cmd.sel == ovr_pkg::ADDR_FAULTS));

	// sticky flags; a new event in the clearing cycle survives the clear
	always_comb
	begin
		next_flt_mismatch = flt_mismatch;
		next_flt_unmapped = flt_unmapped;
		next_flt_rsvd = flt_rsvd;
		next_flt_sel = flt_sel;
		if (clr_faults)
		begin
			next_flt_mismatch = 1'b0;
			next_flt_unmapped = 1'b0;
			next_flt_rsvd = 1'b0;
			next_flt_sel = '0;
		end
		if (set_mismatch)
		begin
			next_flt_mismatch = 1'b1;
			next_flt_sel = cmd.sel;
		end
		if (set_unmapped)
			next_flt_unmapped = 1'b1;
		if (set_rsvd)
			next_flt_rsvd = 1'b1;
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			flt_mismatch <= ovr_pkg::RESET_FAULTS[ovr_pkg::FLT_MISMATCH];
			flt_unmapped <= ovr_pkg::RESET_FAULTS[ovr_pkg::FLT_UNMAPPED];
			flt_rsvd <= ovr_pkg::RESET_FAULTS[ovr_pkg::FLT_RSVD];
			flt_sel <= ovr_pkg::RESET_FAULTS[ovr_pkg::FLT_SEL_LSB +: ovr_pkg::SEL_W];
		end
		else
		begin
			flt_mismatch <= next_flt_mismatch;
			flt_unmapped <= next_flt_unmapped;
			flt_rsvd <= next_flt_rsvd;
			flt_sel <= next_flt_sel;
		end
	end

	logic [ovr_pkg::WORD_W-1:0] flt_word;

	// fault word image, unused bits zero
	always_comb
	begin
		flt_word = '0;
		flt_word[ovr_pkg::FLT_MISMATCH] = flt_mismatch;
		flt_word[ovr_pkg::FLT_UNMAPPED] = flt_unmapped;
		flt_word[ovr_pkg::FLT_RSVD] = flt_rsvd;
		flt_word[ovr_pkg::FLT_SEL_LSB +: ovr_pkg::SEL_W] = flt_sel;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [ovr_pkg::WORD_W-1:0] next_rdata;
	logic next_rdata_valid;
	logic [ovr_pkg::SEL_W-1:0] rd_addr;

	// a plain read uses the port address, a read request the select in the word
	assign rd_addr = RD ? ADDR : cmd.sel;

	// data stand only in the cycle after the strobe; otherwise the bus reads zero
	always_comb
	begin
		next_rdata = '0;
		next_rdata_valid = RD || rd_cmd;
		if (next_rdata_valid)
		begin
			if (rd_addr == ovr_pkg::ADDR_GROUP_A)
				next_rdata = word_a;
			else if (rd_addr == ovr_pkg::ADDR_GROUP_B)
				next_rdata = word_b;
			else if (rd_addr == ovr_pkg::ADDR_FAULTS)
				next_rdata = flt_word;
			else
				next_rdata = '0;
		end
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			RDATA <= '0;
			RDATA_VALID <= 1'b0;
		end
		else
		begin
			RDATA <= next_rdata;
			RDATA_VALID <= next_rdata_valid;
		end
	end

	// ----------------------------------------------------------------
	// per-channel span
	// ----------------------------------------------------------------
	// range inputs come from same-clock register logic, so no synchroniser
	logic [CHANNELS*ovr_pkg::FS_W-1:0] fs_a;
	logic [CHANNELS*ovr_pkg::FS_W-1:0] fs_b;

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++)
		begin : g_chan
			// low half pairs with the lower range register, high half with the upper
			ovr_range_decode u_dec_a
			(
				.code(RANGE_A[2*ch +: 2]),
				.headroom(word_a.en[ch]),
				.fs_mv(fs_a[ch*ovr_pkg::FS_W +: ovr_pkg::FS_W])
			);

			ovr_range_decode u_dec_b
			(
				.code(RANGE_B[2*ch +: 2]),
				.headroom(word_b.en[ch]),
				.fs_mv(fs_b[ch*ovr_pkg::FS_W +: ovr_pkg::FS_W])
			);
		end
	endgenerate

	logic [CHANNELS*ovr_pkg::FS_W-1:0] next_fs_a;
	logic [CHANNELS*ovr_pkg::FS_W-1:0] next_fs_b;
	logic [CHANNELS-1:0] next_hr_a;
	logic [CHANNELS-1:0] next_hr_b;

	// registered outputs lag the stored enables by one cycle; fine for a slow analog setting
	always_comb
	begin
		next_fs_a = fs_a;
		next_fs_b = fs_b;
		next_hr_a = word_a.en;
		next_hr_b = word_b.en;
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			FULL_SCALE_A <= '0;
			FULL_SCALE_B <= '0;
			HEADROOM_A <= '0;
			HEADROOM_B <= '0;
		end
		else
		begin
			FULL_SCALE_A <= next_fs_a;
			FULL_SCALE_B <= next_fs_b;
			HEADROOM_A <= next_hr_a;
			HEADROOM_B <= next_hr_b;
		end
	end

endmodule
`default_nettype wire

// *** shared/ovr_pkg.sv ***
package ovr_pkg;

	// ----------------------------------------------------------------
	// register word layout
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int SEL_W = 6;
	localparam int EN_W = 8;
	localparam int DIR_BIT = 15;
	localparam int SEL_MSB = 14;
	localparam int SEL_LSB = 9;
	localparam int RSVD_BIT = 8;

	// direction bit values
	localparam logic DIR_READ = 1'b0;
	localparam logic DIR_WRITE = 1'b1;

	// ----------------------------------------------------------------
	// register map and reset values
	// ----------------------------------------------------------------
	localparam logic [SEL_W-1:0] ADDR_GROUP_A = 6'h0a;
	localparam logic [SEL_W-1:0] ADDR_GROUP_B = 6'h0b;
	localparam logic [SEL_W-1:0] ADDR_FAULTS = 6'h3e;
	localparam logic [WORD_W-1:0] RESET_GROUP_A = 16'h1400;
	localparam logic [WORD_W-1:0] RESET_GROUP_B = 16'h1600;
	localparam logic [WORD_W-1:0] RESET_FAULTS = 16'h0000;

	// range registers feeding each half group (addresses kept for reference)
	localparam logic [SEL_W-1:0] ADDR_RANGE_A_LO = 6'h04;
	localparam logic [SEL_W-1:0] ADDR_RANGE_A_HI = 6'h05;
	localparam logic [SEL_W-1:0] ADDR_RANGE_B_LO = 6'h06;
	localparam logic [SEL_W-1:0] ADDR_RANGE_B_HI = 6'h07;

	// fault register field positions
	localparam int FLT_MISMATCH = 0;
	localparam int FLT_UNMAPPED = 1;
	localparam int FLT_RSVD = 2;
	localparam int FLT_SEL_LSB = 8;

	// ----------------------------------------------------------------
	// range codes and full-scale values in millivolts
	// ----------------------------------------------------------------
	localparam int FS_W = 14;
	localparam logic [1:0] CODE_10V_ALT = 2'h0;
	localparam logic [1:0] CODE_2V5 = 2'h1;
	localparam logic [1:0] CODE_5V = 2'h2;
	localparam logic [1:0] CODE_10V = 2'h3;
	localparam int FS_10V_MV = 10000;
	localparam int FS_5V_MV = 5000;
	localparam int FS_2V5_MV = 2500;
	localparam int OVR_PERCENT = 20;

	typedef struct packed {
		logic dir;
		logic [SEL_W-1:0] sel;
		logic rsvd;
		logic [EN_W-1:0] en;
	} ovr_word_t;

	typedef logic [FS_W-1:0] ovr_fs_t;

endpackage

// *** src/ovr_range_decode.sv ***
`timescale 1ns/10ps
`default_nettype none

// turns a channel range code and its headroom enable into full scale in mV
module ovr_range_decode
(
	// channel setting
	input wire logic [1:0] code,
	input wire logic headroom,
	// resulting span
	output ovr_pkg::ovr_fs_t fs_mv
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	localparam int SCALE = 100 + ovr_pkg::OVR_PERCENT;

	// both end codes select 10 V, so an unprogrammed channel is never narrow
	function automatic int base_mv(input logic [1:0] c);
		int v;
		v = ovr_pkg::FS_10V_MV;
		case (c)
			ovr_pkg::CODE_2V5: v = ovr_pkg::FS_2V5_MV;
			ovr_pkg::CODE_5V: v = ovr_pkg::FS_5V_MV;
			default: v = ovr_pkg::FS_10V_MV;
		endcase
		return v;
	endfunction

	// widened span is exact: all bases are multiples of 100 mV
	always_comb
	begin
		if (headroom)
			fs_mv = ovr_pkg::ovr_fs_t'(base_mv(code) * SCALE / 100);
		else
			fs_mv = ovr_pkg::ovr_fs_t'(base_mv(code));
	end

endmodule
`default_nettype wire

// *** src/ovr_group_reg.sv ***
`timescale 1ns/10ps
`default_nettype none

// one group's eight headroom enables with its fixed register word
module ovr_group_reg
#(
	parameter logic [ovr_pkg::WORD_W-1:0] RESET_WORD = ovr_pkg::RESET_GROUP_A
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// write side
	input wire logic wr_en,
	input wire logic [ovr_pkg::EN_W-1:0] wr_bits,
	// stored state
	output ovr_pkg::ovr_word_t word
);

	logic [ovr_pkg::EN_W-1:0] en;
	logic [ovr_pkg::EN_W-1:0] next_en;

	// only the enables are stored; the rest of the word is constant
	always_comb
	begin
		next_en = en;
		if (wr_en)
			next_en = wr_bits;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			en <= RESET_WORD[ovr_pkg::EN_W-1:0];
		else
			en <= next_en;
	end

	// read word: direction reads as read, select is own address, reserved zero
	always_comb
	begin
		word.dir = ovr_pkg::DIR_READ;
		word.sel = RESET_WORD[ovr_pkg::SEL_MSB:ovr_pkg::SEL_LSB];
		word.rsvd = 1'b0;
		word.en = en;
	end

endmodule
`default_nettype wire

// *** testbench/ovr_top_sva.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// port checks for the headroom enable registers
// ----------------------------------------------------------------
module ovr_top_sva
#(
	parameter int CHANNELS = 8
)
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// register port
	input wire logic [ovr_pkg::SEL_W-1:0] ADDR,
	input wire logic [ovr_pkg::WORD_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [ovr_pkg::WORD_W-1:0] RDATA,
	input wire logic RDATA_VALID,
	// channel side
	input wire logic [2*CHANNELS-1:0] RANGE_A,
	input wire logic [2*CHANNELS-1:0] RANGE_B,
	input wire logic [CHANNELS-1:0] HEADROOM_A,
	input wire logic [CHANNELS-1:0] HEADROOM_B,
	input wire logic [CHANNELS*ovr_pkg::FS_W-1:0] FULL_SCALE_A,
	input wire logic [CHANNELS*ovr_pkg::FS_W-1:0] FULL_SCALE_B
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	logic is_rq;
	logic [ovr_pkg::SEL_W-1:0] rq_sel;
	logic grp_rq;

	// a read strobe or a write word with direction 0 both ask for an answer
	assign is_rq = RD || (WR && WDATA[ovr_pkg::DIR_BIT] == ovr_pkg::DIR_READ);
	// the reserved bit only means something in the two enable registers, not the fault word
	assign rq_sel = RD ? ADDR : WDATA[ovr_pkg::SEL_MSB:ovr_pkg::SEL_LSB];
	assign grp_rq = is_rq && (rq_sel == ovr_pkg::ADDR_GROUP_A || rq_sel == ovr_pkg::ADDR_GROUP_B);

	// own span decode, so a slip in the design's table cannot hide behind shared code
	function automatic logic [13:0] span(input logic [1:0] c, input logic e);
		int base;
		base = (c == ovr_pkg::CODE_2V5) ? ovr_pkg::FS_2V5_MV :
			(c == ovr_pkg::CODE_5V) ? ovr_pkg::FS_5V_MV : ovr_pkg::FS_10V_MV;
		return 14'(e ? base * (100 + ovr_pkg::OVR_PERCENT) / 100 : base);
	endfunction

	property p_answer; is_rq |=> RDATA_VALID; endproperty
	a_answer: assert property (p_answer) else $error("read answer missing");
	property p_quiet; !is_rq |=> !RDATA_VALID && RDATA == 16'h0000; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without request");
	property p_rsvd; grp_rq |=> RDATA[8] == 1'b0 && RDATA[15] == 1'b0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
	property p_read_a;
		RD && ADDR == ovr_pkg::ADDR_GROUP_A |=> RDATA == {1'b0, ovr_pkg::ADDR_GROUP_A, 1'b0, HEADROOM_A};
	endproperty
	a_read_a: assert property (p_read_a) else $error("group a word wrong");
	property p_read_b;
		RD && ADDR == ovr_pkg::ADDR_GROUP_B |=> RDATA == {1'b0, ovr_pkg::ADDR_GROUP_B, 1'b0, HEADROOM_B};
	endproperty
	a_read_b: assert property (p_read_b) else $error("group b word wrong");
	property p_write_a;
		WR && WDATA[15] && WDATA[14:9] == ovr_pkg::ADDR_GROUP_A && ADDR == ovr_pkg::ADDR_GROUP_A
			|-> ##2 HEADROOM_A == $past(WDATA[7:0], 2);
	endproperty
	a_write_a: assert property (p_write_a) else $error("group a enables not stored");
	property p_write_b;
		WR && WDATA[15] && WDATA[14:9] == ovr_pkg::ADDR_GROUP_B && ADDR == ovr_pkg::ADDR_GROUP_B
			|-> ##2 HEADROOM_B == $past(WDATA[7:0], 2);
	endproperty
	a_write_b: assert property (p_write_b) else $error("group b enables not stored");
	property p_span_a; !$past(RST) |-> FULL_SCALE_A[13:0] == span($past(RANGE_A[1:0]), HEADROOM_A[0]); endproperty
	a_span_a: assert property (p_span_a) else $error("group a channel 0 span wrong");
	property p_span_b;
		!$past(RST) |-> FULL_SCALE_B[14*CHANNELS-1 -: 14] ==
			span($past(RANGE_B[2*CHANNELS-1 -: 2]), HEADROOM_B[CHANNELS-1]);
	endproperty
	a_span_b: assert property (p_span_b) else $error("group b channel 7 span wrong");

	c_write_a: cover property (WR && WDATA[15] && ADDR == ovr_pkg::ADDR_GROUP_A);
	c_read_b: cover property (RD && ADDR == ovr_pkg::ADDR_GROUP_B);
	c_request: cover property (WR && !WDATA[15]);
endmodule

bind ovr_top ovr_top_sva #(.CHANNELS(CHANNELS)) u_sva (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID), .RANGE_A(RANGE_A), .RANGE_B(RANGE_B),
	.HEADROOM_A(HEADROOM_A), .HEADROOM_B(HEADROOM_B), .FULL_SCALE_A(FULL_SCALE_A), .FULL_SCALE_B(FULL_SCALE_B));

`default_nettype wire

// *** testbench/ovr_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// host controller issuing register words
// ----------------------------------------------------------------
module ovr_host_model
(
	// clock
	input wire logic mclk,
	// register port towards the device
	output logic [ovr_pkg::SEL_W-1:0] addr,
	output logic [ovr_pkg::WORD_W-1:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [ovr_pkg::WORD_W-1:0] rdata,
	input wire logic rdata_valid
);
	// quiet bus at time zero
	initial
	begin
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one access; strobe lasts one cycle and the answer is taken in the next
	task automatic acc(input logic r, input logic [5:0] a, input logic [15:0] w, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= w;
		rd <= r;
		wr <= !r;
		@(posedge mclk);
		rd <= 1'b0;
		wr <= 1'b0;
		// idle lines carry the inverse so late sampling shows up
		addr <= ~a;
		wdata <= ~w;
		#1 d = (rdata_valid === 1'b1) ? rdata : 'x;
	endtask
endmodule

`default_nettype wire

// *** testbench/tb_ovr_top.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// register and span tests for the headroom enables
// ----------------------------------------------------------------
module tb_ovr_top;
	localparam logic [7:0] en_a = 8'ha5;
	localparam logic [7:0] en_b = 8'h5a;
	logic mclk, rst, wr, rd, rdata_valid;
	logic [5:0] addr;
	logic [15:0] wdata, rdata, d, range_a, range_b;
	logic [7:0] head_a, head_b;
	logic [111:0] fs_a, fs_b;
	int bad_count = 0;
	int checked = 0;

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	ovr_top #(.CHANNELS(8)) uut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .RDATA_VALID(rdata_valid), .RANGE_A(range_a), .RANGE_B(range_b),
		.HEADROOM_A(head_a), .HEADROOM_B(head_b), .FULL_SCALE_A(fs_a), .FULL_SCALE_B(fs_b));
	ovr_host_model host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.rdata_valid(rdata_valid));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// expected span in mV, widened by the headroom percentage when enabled
	function automatic logic [15:0] span(input logic [1:0] c, input logic e);
		int base;
		base = (c == 2'h1) ? ovr_pkg::FS_2V5_MV : (c == 2'h2) ? ovr_pkg::FS_5V_MV : ovr_pkg::FS_10V_MV;
		return 16'(e ? base * (100 + ovr_pkg::OVR_PERCENT) / 100 : base);
	endfunction

	// cuts a hang short; every access is fixed-length so this only trips on a stuck run
	initial
	begin
		#1000000;
		bad_count++;
		conclude();
	end

	initial
	begin
		rst = 1'b1;
		range_a = 16'hffff;
		range_b = 16'hffff;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		host.acc(1'b1, 6'h0a, 16'h0000, d); chk(d, 16'h1400);
		host.acc(1'b1, 6'h0b, 16'h0000, d); chk(d, 16'h1600);
		chk({head_a, head_b}, 16'h0000);
		$display("test reset words done");
		// reserved bit set on both writes must not stick
		host.acc(1'b0, 6'h0a, {8'h95, en_a}, d);
		host.acc(1'b0, 6'h0b, {8'h97, en_b}, d);
		host.acc(1'b1, 6'h0a, 16'h0000, d); chk(d, 16'h14a5);
		host.acc(1'b0, 6'h3f, 16'h1600, d); chk(d, 16'h165a);
		chk({head_a, head_b}, {en_a, en_b});
		$display("test write and read back done");
		// wrong select and direction 0 leave the store alone
		host.acc(1'b0, 6'h0a, {1'b1, 6'h0b, 9'h000}, d);
		host.acc(1'b0, 6'h0b, 16'h16ff, d); chk(d, 16'h165a);
		host.acc(1'b1, 6'h0a, 16'h0000, d); chk(d, 16'h14a5);
		host.acc(1'b1, 6'h01, 16'h0000, d); chk(d, 16'h0000);
		$display("test refused writes done");
		// fault word: mismatch, unmapped and reserved flags with select 0x0b, cleared by the read
		host.acc(1'b1, 6'h3e, 16'h0000, d); chk(d, 16'h0b07);
		host.acc(1'b1, 6'h3e, 16'h0000, d); chk(d, 16'h0000);
		$display("test fault word done");
		// every range code on every channel, enables mixed
		for (int c = 0; c < 4; c++)
		begin
			@(posedge mclk);
			range_a <= {8{2'(c)}};
			range_b <= {8{2'(c)}};
			repeat (2) @(posedge mclk);
			#1;
			for (int n = 0; n < 8; n++)
			begin
				chk({2'h0, fs_a[14*n +: 14]}, span(2'(c), en_a[n]));
				chk({2'h0, fs_b[14*n +: 14]}, span(2'(c), en_b[n]));
			end
		end
		$display("test span sweep done");
		// reset in mid-run brings back the reset words
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		host.acc(1'b1, 6'h0a, 16'h0000, d); chk(d, 16'h1400);
		host.acc(1'b1, 6'h0b, 16'h0000, d); chk(d, 16'h1600);
		$display("test second reset done");
		conclude();
	end
endmodule

`default_nettype wire
